// *** gks_pkg.sv ***
package gks_pkg;

   // Pressure codes count in steps of one ten-thousandth of a millibar.
   localparam int unsigned GKS_PW = 24;
   typedef logic [GKS_PW-1:0] gks_press_t;

   // The four user settings, kept together so they move as one word to storage.
   typedef struct packed {
      gks_press_t sp_on;   // Relay turn-on setpoint.
      gks_press_t sp_off;  // Relay turn-off setpoint.
      gks_press_t zero;    // User zero offset.
      gks_press_t span;    // Span (atmosphere) value.
   } gks_set_t;

   // Factory defaults: 0.1 mbar, 0.2 mbar, zero, 1.01 bar.
   localparam gks_press_t GKS_DEF_SP_ON  = 24'h0003e8;
   localparam gks_press_t GKS_DEF_SP_OFF = 24'h0007d0;
   localparam gks_press_t GKS_DEF_ZERO   = 24'h000000;
   localparam gks_press_t GKS_DEF_SPAN   = 24'h9a1d20;
   localparam gks_press_t GKS_DEF_STEP   = 24'h000064;
   localparam gks_set_t   GKS_DEF_SET    = '{GKS_DEF_SP_ON, GKS_DEF_SP_OFF,
                                             GKS_DEF_ZERO, GKS_DEF_SPAN};

   // Unit boundaries: below 0.1 mbar shows in thousandths, from 1000 mbar in bar.
   localparam gks_press_t GKS_MILLI_LIM  = 24'h0003e8;
   localparam gks_press_t GKS_BAR_LIM    = 24'h989680;

   // Register byte offsets on the plain register port.
   localparam logic [7:0] GKS_OFS_STAT   = 8'h00;
   localparam logic [7:0] GKS_OFS_CTRL   = 8'h04;
   localparam logic [7:0] GKS_OFS_STEP   = 8'h08;
   localparam logic [7:0] GKS_OFS_SP_ON  = 8'h0c;
   localparam logic [7:0] GKS_OFS_SP_OFF = 8'h10;
   localparam logic [7:0] GKS_OFS_ZERO   = 8'h14;
   localparam logic [7:0] GKS_OFS_SPAN   = 8'h18;

   // Field positions and reset values of the control register.
   localparam int unsigned GKS_CTRL_RLY_DIS = 0;
   localparam logic        GKS_RST_RLY_DIS  = 1'b0;

   // Hold times in milliseconds, and the clock rate they are counted at.
   localparam int unsigned GKS_CLK_MHZ     = 200;
   localparam int unsigned GKS_SEL_HOLD_MS = 3000;
   localparam int unsigned GKS_UP_HOLD_MS  = 5000;
   localparam int unsigned GKS_SEL_HOLD_CYC = GKS_SEL_HOLD_MS * GKS_CLK_MHZ * 1000;
   localparam int unsigned GKS_UP_HOLD_CYC  = GKS_UP_HOLD_MS * GKS_CLK_MHZ * 1000;

   // Menu steps.
   typedef enum logic [2:0] {
      GKS_ST_NORM, GKS_ST_DEF, GKS_ST_SP_ON, GKS_ST_SP_OFF, GKS_ST_ZERO, GKS_ST_SPAN
   } gks_state_t;

   // What the readout shows.
   typedef enum logic [1:0] {
      GKS_DSP_PRESS, GKS_DSP_VALUE, GKS_DSP_ZEROS, GKS_DSP_DEF
   } gks_disp_t;

endpackage : gks_pkg

// *** gks_key_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module gks_key_timer
   import gks_pkg::*;
#(
   parameter int unsigned HOLD_CYC = GKS_SEL_HOLD_CYC
) (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic sys_rst,
   // Raw switch contact, active high, asynchronous to clk.
   input  wire logic pin,
   // Conditioned action.
   output logic      press,
   output logic      hold_hit,
   output logic      rel_short
);

   // A hold time of one cycle leaves no room to tell a press from a hold.
   generate
      if (HOLD_CYC < 2) begin : g_bad_hold
         $error("gks_key_timer: HOLD_CYC must be at least 2");
      end
   endgenerate

   logic        sync1_ff;   // First synchroniser stage, read only by the second.
   logic        sync2_ff;   // Synchronised contact level.
   logic        held_ff;    // Delayed level for edge detection.
   logic [31:0] cnt_ff;     // Cycles the action has been held.
   logic        press_ff;
   logic        hold_ff;
   logic        rel_ff;
   logic [31:0] nxt_cnt;
   logic        nxt_press;
   logic        nxt_hold;
   logic        nxt_rel;

   // The counter stops at the hold time, so a hold fires once per press.
   always_comb begin
      nxt_press = sync2_ff & ~held_ff;
      nxt_cnt   = cnt_ff;
      nxt_hold  = 1'b0;
      nxt_rel   = ~sync2_ff & held_ff & (cnt_ff < HOLD_CYC);
      if (!sync2_ff) begin
         nxt_cnt = 32'h00000000;
      end else if (cnt_ff < HOLD_CYC) begin
         nxt_cnt  = cnt_ff + 32'h00000001;
         nxt_hold = (cnt_ff == HOLD_CYC - 1);
      end
   end

   // Registers only; reset clears every flag and count.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         held_ff  <= 1'b0;
         cnt_ff   <= 32'h00000000;
         press_ff <= 1'b0;
         hold_ff  <= 1'b0;
         rel_ff   <= 1'b0;
      end else begin
         sync1_ff <= pin;
         sync2_ff <= sync1_ff;
         held_ff  <= sync2_ff;
         cnt_ff   <= nxt_cnt;
         press_ff <= nxt_press;
         hold_ff  <= nxt_hold;
         rel_ff   <= nxt_rel;
      end
   end

   assign press     = press_ff;
   assign hold_hit  = hold_ff;
   assign rel_short = rel_ff;

endmodule : gks_key_timer
`default_nettype wire

// *** gks_relay.sv ***
`timescale 1ns/100ps
`default_nettype none
module gks_relay
   import gks_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Measured pressure and the two setpoints.
   input  wire gks_press_t press,
   input  wire gks_press_t sp_on,
   input  wire gks_press_t sp_off,
   // Forces the relay off.
   input  wire logic       disable_rly,
   // Relay drive, high while energized.
   output logic            relay
);

   logic relay_ff;
   logic nxt_relay;

   // Between the two setpoints the relay keeps its state, which gives hysteresis.
   always_comb begin
      nxt_relay = relay_ff;
      if (disable_rly) begin
         nxt_relay = 1'b0;
      end else if (press < sp_on) begin
         nxt_relay = 1'b1;
      end else if (press > sp_off) begin
         nxt_relay = 1'b0;
      end else begin
         nxt_relay = relay_ff;
      end
   end

   // Relay starts de-energized.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         relay_ff <= 1'b0;
      end else begin
         relay_ff <= nxt_relay;
      end
   end

   assign relay = relay_ff;

endmodule : gks_relay
`default_nettype wire

// *** gks_menu.sv ***
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module gks_menu
   import gks_pkg::*;
#(
   parameter int unsigned SEL_HOLD_CYC = GKS_SEL_HOLD_CYC,
   parameter int unsigned UP_HOLD_CYC  = GKS_UP_HOLD_CYC
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Three-position switch contacts, active high.
   input  wire logic        sw_select,
   input  wire logic        sw_up,
   input  wire logic        sw_down,
   // Measured pressure and raw sensor reading, same clock.
   input  wire gks_press_t  pressure,
   input  wire gks_press_t  sensor_raw,
   // Non-volatile storage: load at start-up, write on every change.
   input  wire logic        nv_load,
   input  wire gks_set_t    nv_rd_set,
   output logic             nv_wr_ff,
   output gks_set_t         settings_ff,
   // Front panel.
   output logic             led_green_ff,
   output logic             led_red_ff,
   output gks_disp_t        disp_mode_ff,
   output gks_press_t       disp_val_ff,
   output logic             relay_ff,
   // Register port.
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata_ff
);

   // A hold shorter than two cycles cannot be timed.
   generate
      if (SEL_HOLD_CYC < 2 || UP_HOLD_CYC < 2) begin : g_bad_hold
         $error("gks_menu: hold counts must be at least 2");
      end
   endgenerate

   // Conditioned actions from the three contacts.
   logic sel_press, sel_hold, sel_short;
   logic up_press, up_hold, up_short;
   logic dn_press;

   // Each switch position is its own contact, so the three actions stay distinct.
   gks_key_timer #(.HOLD_CYC(SEL_HOLD_CYC)) u_sel (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pin       (sw_select),
      .press     (sel_press),
      .hold_hit  (sel_hold),
      .rel_short (sel_short)
   );

   gks_key_timer #(.HOLD_CYC(UP_HOLD_CYC)) u_up (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pin       (sw_up),
      .press     (up_press),
      .hold_hit  (up_hold),
      .rel_short (up_short)
   );

   gks_key_timer #(.HOLD_CYC(SEL_HOLD_CYC)) u_dn (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .pin       (sw_down),
      .press     (dn_press),
      .hold_hit  (),
      .rel_short ()
   );

   // Menu state and its outputs.
   gks_state_t state_ff;      // Current menu step.
   gks_state_t nxt_state;
   gks_press_t shown_ff;      // Value being edited in a setpoint or span step.
   gks_press_t nxt_shown;
   logic       sel_arm_ff;    // A select press began inside the current step.
   logic       nxt_sel_arm;
   gks_set_t   nxt_set;
   logic       nxt_nv_wr;
   gks_disp_t  nxt_disp_mode;
   gks_press_t nxt_disp_val;
   logic       nxt_green;
   logic       nxt_red;

   // Software-owned control.
   logic       rly_dis_ff;    // Holds the relay off.
   logic       nxt_rly_dis;
   gks_press_t step_ff;       // Increment of one up or down action.
   gks_press_t nxt_step;
   logic [31:0] nxt_rdata;

   // Saturating edit of the shown value, so it never wraps past the ends.
   function automatic gks_press_t adjust(input gks_press_t v, input gks_press_t s,
                                         input logic up, input logic dn);
      gks_press_t r;
      r = v;
      if (up) begin
         r = (v > ~s) ? '1 : v + s;
      end else if (dn) begin
         r = (v < s) ? '0 : v - s;
      end
      return r;
   endfunction : adjust

   // Menu sequencing.
   always_comb begin
      nxt_state   = state_ff;
      nxt_shown   = shown_ff;
      nxt_set     = settings_ff;
      nxt_nv_wr   = 1'b0;
      nxt_sel_arm = sel_arm_ff | sel_press;
      case (state_ff)
         GKS_ST_NORM: begin
            if (sel_hold) begin
               nxt_state = GKS_ST_SP_ON;
               nxt_shown = settings_ff.sp_on;
            end else if (up_press) begin
               nxt_state = GKS_ST_DEF;
            end
         end
         GKS_ST_DEF: begin
            if (up_hold) begin
               nxt_set   = GKS_DEF_SET;
               nxt_nv_wr = 1'b1;
               nxt_state = GKS_ST_NORM;
            end else if (up_short) begin
               nxt_state = GKS_ST_NORM;
            end
         end
         GKS_ST_SP_ON: begin
            nxt_shown = adjust(shown_ff, step_ff, up_press, dn_press);
            if (sel_press) begin
               nxt_set.sp_on = shown_ff;
               nxt_nv_wr     = (shown_ff != settings_ff.sp_on);
               nxt_shown     = settings_ff.sp_off;
               nxt_state     = GKS_ST_SP_OFF;
            end
         end
         GKS_ST_SP_OFF: begin
            nxt_shown = adjust(shown_ff, step_ff, up_press, dn_press);
            if (sel_press) begin
               nxt_set.sp_off = shown_ff;
               nxt_nv_wr      = (shown_ff != settings_ff.sp_off);
               nxt_state      = GKS_ST_ZERO;
            end
         end
         GKS_ST_ZERO: begin
            if (dn_press) begin
               nxt_set.zero = sensor_raw;
               nxt_nv_wr    = 1'b1;
               nxt_shown    = settings_ff.span;
               nxt_state    = GKS_ST_SPAN;
            end else if (sel_press) begin
               nxt_shown = settings_ff.span;
               nxt_state = GKS_ST_SPAN;
            end
         end
         GKS_ST_SPAN: begin
            nxt_shown = adjust(shown_ff, step_ff, up_press, dn_press);
            if (sel_hold && sel_arm_ff) begin
               nxt_set.span = shown_ff;
               nxt_nv_wr    = 1'b1;
               nxt_state    = GKS_ST_NORM;
            end else if (sel_short && sel_arm_ff) begin
               nxt_state = GKS_ST_NORM;
            end
         end
         default: begin
            nxt_state = GKS_ST_NORM;
         end
      endcase
      // The select that left the previous step must not act in the new one.
      if (nxt_state != state_ff) begin
         nxt_sel_arm = 1'b0;
      end
      // Start-up load from storage yields to nothing the operator is doing.
      if (nv_load) begin
         nxt_set   = nv_rd_set;
         nxt_nv_wr = 1'b0;
      end
   end

   // Readout and unit LEDs follow the value being shown.
   always_comb begin
      nxt_disp_mode = GKS_DSP_PRESS;
      nxt_disp_val  = pressure;
      case (nxt_state)
         GKS_ST_DEF: begin
            nxt_disp_mode = GKS_DSP_DEF;
         end
         GKS_ST_ZERO: begin
            nxt_disp_mode = GKS_DSP_ZEROS;
            nxt_disp_val  = GKS_DEF_ZERO;
         end
         GKS_ST_SP_ON, GKS_ST_SP_OFF, GKS_ST_SPAN: begin
            nxt_disp_mode = GKS_DSP_VALUE;
            nxt_disp_val  = nxt_shown;
         end
         default: begin
            nxt_disp_mode = GKS_DSP_PRESS;
         end
      endcase
      if (nxt_disp_val < GKS_MILLI_LIM) begin
         nxt_green = 1'b1;
         nxt_red   = 1'b1;
      end else if (nxt_disp_val < GKS_BAR_LIM) begin
         nxt_green = 1'b1;
         nxt_red   = 1'b0;
      end else begin
         nxt_green = 1'b0;
         nxt_red   = 1'b1;
      end
   end

   // Register port: writes steer control, reads show state one cycle later.
   always_comb begin
      nxt_rly_dis = rly_dis_ff;
      nxt_step    = step_ff;
      nxt_rdata   = 32'h00000000;
      if (reg_wr) begin
         case (reg_addr)
            GKS_OFS_CTRL: nxt_rly_dis = reg_wdata[GKS_CTRL_RLY_DIS];
            GKS_OFS_STEP: nxt_step    = reg_wdata[GKS_PW-1:0];
            default:      nxt_step    = step_ff;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            GKS_OFS_STAT:   nxt_rdata = {26'h0000000, state_ff, relay_ff,
                                         led_red_ff, led_green_ff};
            GKS_OFS_CTRL:   nxt_rdata = {31'h00000000, rly_dis_ff};
            GKS_OFS_STEP:   nxt_rdata = {8'h00, step_ff};
            GKS_OFS_SP_ON:  nxt_rdata = {8'h00, settings_ff.sp_on};
            GKS_OFS_SP_OFF: nxt_rdata = {8'h00, settings_ff.sp_off};
            GKS_OFS_ZERO:   nxt_rdata = {8'h00, settings_ff.zero};
            GKS_OFS_SPAN:   nxt_rdata = {8'h00, settings_ff.span};
            default:        nxt_rdata = 32'h00000000;
         endcase
      end
   end

   // Relay with hysteresis; its output is already a flip-flop.
   gks_relay u_relay (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .press       (pressure),
      .sp_on       (settings_ff.sp_on),
      .sp_off      (settings_ff.sp_off),
      .disable_rly (rly_dis_ff),
      .relay       (relay_ff)
   );

   // All state registers. Settings reset to factory values until storage loads.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_ff     <= GKS_ST_NORM;
         shown_ff     <= GKS_DEF_SP_ON;
         sel_arm_ff   <= 1'b0;
         settings_ff  <= GKS_DEF_SET;
         nv_wr_ff     <= 1'b0;
         disp_mode_ff <= GKS_DSP_PRESS;
         disp_val_ff  <= GKS_DEF_ZERO;
         led_green_ff <= 1'b1;
         led_red_ff   <= 1'b1;
         rly_dis_ff   <= GKS_RST_RLY_DIS;
         step_ff      <= GKS_DEF_STEP;
         reg_rdata_ff <= 32'h00000000;
      end else begin
         state_ff     <= nxt_state;
         shown_ff     <= nxt_shown;
         sel_arm_ff   <= nxt_sel_arm;
         settings_ff  <= nxt_set;
         nv_wr_ff     <= nxt_nv_wr;
         disp_mode_ff <= nxt_disp_mode;
         disp_val_ff  <= nxt_disp_val;
         led_green_ff <= nxt_green;
         led_red_ff   <= nxt_red;
         rly_dis_ff   <= nxt_rly_dis;
         step_ff      <= nxt_step;
         reg_rdata_ff <= nxt_rdata;
      end
   end

endmodule : gks_menu
`default_nettype wire

// *** gks_menu_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module gks_menu_checker
   import gks_pkg::*;
#(
   parameter int unsigned SEL_HOLD_CYC = GKS_SEL_HOLD_CYC,
   parameter int unsigned UP_HOLD_CYC  = GKS_UP_HOLD_CYC
) (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        sys_rst,
   // Switch, sensor and storage inputs.
   input wire logic        sw_select,
   input wire logic        sw_up,
   input wire logic        sw_down,
   input wire gks_press_t  pressure,
   input wire gks_press_t  sensor_raw,
   input wire logic        nv_load,
   input wire gks_set_t    nv_rd_set,
   // Block outputs.
   input wire logic        nv_wr_ff,
   input wire gks_set_t    settings_ff,
   input wire logic        led_green_ff,
   input wire logic        led_red_ff,
   input wire gks_disp_t   disp_mode_ff,
   input wire gks_press_t  disp_val_ff,
   input wire logic        relay_ff,
   // Register port.
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata_ff
);
   logic dis_ff;   // Shadow of the relay disable bit, hidden inside the block.
   logic nxt_dis;  // Next value of the shadow.

   // The shadow follows every write to the control offset.
   always_comb begin
      nxt_dis = dis_ff;
      if (reg_wr && reg_addr == GKS_OFS_CTRL) begin
         nxt_dis = reg_wdata[GKS_CTRL_RLY_DIS];
      end
   end

   // Reset puts the shadow where the control register itself starts.
   always_ff @(posedge clk) begin
      dis_ff <= sys_rst ? GKS_RST_RLY_DIS : nxt_dis;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   relay_on_a: assert property (!dis_ff && pressure < settings_ff.sp_on |=> relay_ff)
      else $error("relay not energized below turn-on setpoint");
   relay_off_a: assert property (dis_ff || pressure > settings_ff.sp_off |=> !relay_ff)
      else $error("relay not released above turn-off setpoint");
   relay_hold_a: assert property (!dis_ff && pressure >= settings_ff.sp_on
      && pressure <= settings_ff.sp_off |=> $stable(relay_ff))
      else $error("relay changed between setpoints");
   led_unit_a: assert property ({led_red_ff, led_green_ff} ==
      ((disp_val_ff < GKS_MILLI_LIM) ? 2'h3 : (disp_val_ff < GKS_BAR_LIM) ? 2'h1 : 2'h2))
      else $error("unit lamps disagree with shown value");
   zero_show_a: assert property (disp_mode_ff == GKS_DSP_ZEROS |-> disp_val_ff == '0)
      else $error("zero step does not show zeros");
   rd_setpt_a: assert property (reg_rd && reg_addr == GKS_OFS_SP_OFF |=>
      reg_rdata_ff == {8'h00, $past(settings_ff.sp_off)})
      else $error("turn-off setpoint read wrong");
   rd_stat_a: assert property (reg_rd && reg_addr == GKS_OFS_STAT |=> reg_rdata_ff[2:0]
      == {$past(relay_ff), $past(led_red_ff), $past(led_green_ff)})
      else $error("status read wrong");
   nv_load_a: assert property (nv_load |=> settings_ff == $past(nv_rd_set))
      else $error("stored settings not loaded");
   nv_pulse_a: assert property (nv_wr_ff |=> !nv_wr_ff)
      else $error("storage write longer than one cycle");
   rst_def_a: assert property ($fell(sys_rst) |-> settings_ff == GKS_DEF_SET)
      else $error("settings not at defaults after reset");
endmodule : gks_menu_checker

bind gks_menu gks_menu_checker #(.SEL_HOLD_CYC(SEL_HOLD_CYC), .UP_HOLD_CYC(UP_HOLD_CYC))
   gks_menu_checker_i (.*);
`default_nettype wire

// *** gks_operator.sv ***
`timescale 1ns/100ps
`default_nettype none
module gks_operator (
   // Clock the hands are timed against.
   input  wire logic clk,
   // Switch contacts; an open contact reads low.
   output logic      sw_select,
   output logic      sw_up,
   output logic      sw_down
);
   // The switch rests in its middle position at power-up.
   initial begin
      {sw_select, sw_up, sw_down} = 3'h0;
   end

   // One lever can sit in only one position, so one contact closes at a time.
   task automatic hold_on(input int k);
      @(posedge clk);
      sw_select <= (k == 0);
      sw_up     <= (k == 1);
      sw_down   <= (k == 2);
   endtask : hold_on

   // Letting go opens all contacts; a rest lets the block settle.
   task automatic let_go();
      @(posedge clk);
      {sw_select, sw_up, sw_down} <= 3'h0;
      repeat (8) @(posedge clk);
   endtask : let_go

   // A push of n+1 cycles in position k.
   task automatic push(input int k, input int n);
      hold_on(k);
      repeat (n) @(posedge clk);
      let_go();
   endtask : push
endmodule : gks_operator
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb
   import gks_pkg::*;
;
   localparam int unsigned SEL_HOLD_CYC = 8;   // Short hold counts keep the run brief.
   localparam int unsigned UP_HOLD_CYC  = 12;
   logic        clk, sys_rst, sw_select, sw_up, sw_down, nv_load, nv_wr_ff, relay_ff;
   logic        led_green_ff, led_red_ff, reg_wr, reg_rd;
   gks_press_t  pressure, sensor_raw, disp_val_ff;
   gks_set_t    nv_rd_set, settings_ff;
   gks_disp_t   disp_mode_ff;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata_ff, d;
   int          fails = 0, n_compared = 0, n_wr = 0, i, w;
   // Pressures either side of each unit boundary and the lamps expected, {red, green}.
   gks_press_t  lp [4] = '{GKS_MILLI_LIM - 24'h1, GKS_MILLI_LIM, GKS_BAR_LIM - 24'h1, GKS_BAR_LIM};
   logic [1:0]  le [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
   // Below, between, above and between the setpoints again, to show the hysteresis.
   gks_press_t  rp [4] = '{GKS_DEF_SP_ON - 24'h1, 24'h0005dc, GKS_DEF_SP_OFF + 24'h1, 24'h0005dc};
   logic        re [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

   gks_menu #(.SEL_HOLD_CYC(SEL_HOLD_CYC), .UP_HOLD_CYC(UP_HOLD_CYC)) gks_menu_i (.*);
   gks_operator gks_operator_i (.*);

   // The 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Storage writes are counted so a restore can be seen to reach storage.
   always @(posedge clk) begin
      if (nv_wr_ff === 1'b1) n_wr++;
   end

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // Read data are taken mid-cycle, where they have settled.
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(negedge clk);
      v = reg_rdata_ff;
      @(posedge clk);
   endtask : rd

   // One idle edge follows each write so strobes never merge.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic key(input int k, input int n);
      gks_operator_i.push(k, n);
   endtask : key

   // Polls the status register for a menu step, with a bounded number of reads.
   task automatic wait_st(input logic [2:0] st);
      d = 'x;
      for (w = 0; w < 50 && d[5:3] !== st; w++) rd(GKS_OFS_STAT, d);
      check("state", d[5:3], st);
   endtask : wait_st

   initial begin
      sys_rst    = 1'b1;
      pressure   = '0;
      sensor_raw = 24'h000012;
      nv_load    = 1'b0;
      nv_rd_set  = '0;
      reg_addr   = '0;
      reg_wdata  = '0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      cyc(4);
      sys_rst <= 1'b0;
      cyc(1);
      check("defaults", settings_ff, GKS_DEF_SET);
      for (i = 0; i < 4; i++) begin
         pressure <= lp[i];
         cyc(4);
         check("unit lamps", {led_red_ff, led_green_ff}, le[i]);
      end
      for (i = 0; i < 4; i++) begin
         pressure <= rp[i];
         cyc(3);
         check("relay", relay_ff, re[i]);
      end
      pressure <= GKS_DEF_SP_ON - 24'h1;
      wr(GKS_OFS_CTRL, 32'h1);
      cyc(2);
      check("relay disabled", relay_ff, 1'b0);
      wr(GKS_OFS_CTRL, 32'h0);
      cyc(2);
      rd(GKS_OFS_STAT, d);
      check("status", d, 32'h00000007);
      wr(GKS_OFS_SP_ON, 32'h1);
      rd(GKS_OFS_SP_ON, d);
      check("sp_on read", d, {8'h00, GKS_DEF_SP_ON});
      rd(8'h40, d);
      check("unmapped", d, 32'h0);
      // First pass: edit the turn-on setpoint, capture zero, leave span alone.
      key(0, SEL_HOLD_CYC + 8);
      wait_st(GKS_ST_SP_ON);
      check("sp_on shown", disp_val_ff, GKS_DEF_SP_ON);
      key(1, 3);
      check("sp_on edit", disp_val_ff, GKS_DEF_SP_ON + GKS_DEF_STEP);
      key(0, 3);
      wait_st(GKS_ST_SP_OFF);
      check("sp_on stored", settings_ff.sp_on, GKS_DEF_SP_ON + GKS_DEF_STEP);
      key(0, 3);
      wait_st(GKS_ST_ZERO);
      check("sp_off kept", settings_ff.sp_off, GKS_DEF_SP_OFF);
      check("zeros shown", disp_mode_ff, GKS_DSP_ZEROS);
      key(2, 3);
      wait_st(GKS_ST_SPAN);
      check("zero captured", settings_ff.zero, 24'h000012);
      check("span shown", disp_val_ff, GKS_DEF_SPAN);
      key(2, 3);
      check("span edit", disp_val_ff, GKS_DEF_SPAN - GKS_DEF_STEP);
      key(0, 3);
      wait_st(GKS_ST_NORM);
      check("span kept", settings_ff.span, GKS_DEF_SPAN);
      // Second pass: keep zero with select, store an edited span by a long select.
      sensor_raw <= 24'h000777;
      key(0, SEL_HOLD_CYC + 8);
      wait_st(GKS_ST_SP_ON);
      for (i = 0; i < 3; i++) key(0, 3);
      wait_st(GKS_ST_SPAN);
      check("zero kept", settings_ff.zero, 24'h000012);
      key(1, 3);
      key(0, SEL_HOLD_CYC + 8);
      wait_st(GKS_ST_NORM);
      check("span stored", settings_ff.span, GKS_DEF_SPAN + GKS_DEF_STEP);
      // An early release of up keeps everything; a full hold restores defaults.
      gks_operator_i.hold_on(1);
      wait_st(GKS_ST_DEF);
      check("dEF shown", disp_mode_ff, GKS_DSP_DEF);
      gks_operator_i.let_go();
      wait_st(GKS_ST_NORM);
      check("kept", settings_ff.sp_on, GKS_DEF_SP_ON + GKS_DEF_STEP);
      i = n_wr;
      key(1, UP_HOLD_CYC + 8);
      wait_st(GKS_ST_NORM);
      check("restored", settings_ff, GKS_DEF_SET);
      check("restore saved", n_wr > i, 1'b1);
      rd(GKS_OFS_SP_OFF, d);
      check("sp_off read", d, {8'h00, GKS_DEF_SP_OFF});
      rd(GKS_OFS_ZERO, d);
      check("zero read", d, {8'h00, GKS_DEF_ZERO});
      rd(GKS_OFS_SPAN, d);
      check("span read", d, {8'h00, GKS_DEF_SPAN});
      // The edit increment is software's own; it must read back as written.
      wr(GKS_OFS_STEP, 32'h00000032);
      rd(GKS_OFS_STEP, d);
      check("step read", d, 32'h00000032);
      // Settings come back from storage at power-up.
      nv_rd_set <= {4{24'h000111}};
      nv_load   <= 1'b1;
      cyc(1);
      nv_load   <= 1'b0;
      cyc(1);
      check("loaded", settings_ff, {4{24'h000111}});
      give_verdict();
   end

   // The tests take well under a thousand cycles; this limit is twenty times that.
   initial begin
      #100000;
      fails++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire
